// ==== hdl/periph_io_space.sv ====
// Functional notes
// R01: upper 128 x words from ffff80 decode as internal i/o space.
// R02: status registers are read-only; writes leave state unchanged. Only host status is read-only here; core status and the timer flag take writes.
// R03: timer flags sit in its combined control/status register.
// R04: a status flag with its enable set raises an interrupt condition.
// R05: host status reports transmit-empty in bit 1.
// R06: accepted interrupt gives source vector; host receive-full is 60.
// R07: two-opcode service code returns automatically.
// R08: long routine runs until return-from-interrupt, then resumes.
// R09: interrupt needs peripheral enable, priority level and global mask.
// R10: each peripheral has two to six interrupt sources; the timer here has one.
// R11: each peripheral has one to four dma request sources.
// R12: dma may only write transmit and only read receive registers.
// R13: dma uses its own address and data buses.
// R14: software holds a peripheral reset or disabled while configuring.
// R15: software avoids changing configuration while active.
// R16: enabled peripheral runs with modes written while disabled.
// R17: software never enables irq and dma for one event together.
// R18: dma selector code 10100 selects host transmit-empty.
// R19: unimplemented window addresses read zero, writes ignored.
// R20: requests are level signals from flags and enables.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module periph_io_space
    import periph_io_pkg::*;
#(
    parameter int host_irq_sources  = 2,
    parameter int host_dma_sources  = 2
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // peripheral events (core clock)
    input  wire logic        host_rx_load,
    input  wire logic [23:0] host_rx_data,
    input  wire logic        host_tx_taken,
    input  wire logic        timer_event,
    // dma bus, own path
    input  wire dma_req_type dma_in,
    output logic [23:0]      dma_rdata,
    output logic             dma_ack,
    // core side
    output logic             irq_req,
    output logic [23:0]      irq_vec,
    output logic             dma_req
);
    initial begin
        if (host_irq_sources < 2 || host_irq_sources > 6) $error("irq sources out of range");  // [R10]
        if (host_dma_sources < 1 || host_dma_sources > 4) $error("dma sources out of range");  // [R11]
    end

    regs_type    q;
    regs_type    d;
    logic        dma_in_win;
    logic [6:0]  dma_idx;
    logic        dma_ok;
    logic        dma_ack_q;
    logic [23:0] dma_rdata_q;

    io_window_decode u_decode (
        .dma_valid (dma_in.valid),
        .dma_write (dma_in.write),
        .dma_addr  (dma_in.addr),
        .in_window (dma_in_win),
        .word_idx  (dma_idx),
        .dma_ok    (dma_ok)
    );

    logic        setup;
    logic        acc;
    logic        known;
    logic        host_tx_empty;
    logic        host_rx_full;
    logic        timer_flag;
    logic        irq_host_rx;
    logic        irq_host_tx;
    logic        irq_timer;
    logic        dma_wr_tx;
    logic        dma_rd_rx;
    logic        sel_hit;

    always_comb begin
        d       = q;
        setup   = psel && !penable;
        acc     = psel && penable && q.pready;
        known   = 1'b1;
        dma_wr_tx = dma_ok && dma_in.write;
        dma_rd_rx = dma_ok && !dma_in.write;
        host_tx_empty = q.host_status[host_tx_empty_bit];
        host_rx_full  = q.host_status[host_rx_full_bit];
        timer_flag    = q.timer_csr[timer_flag_bit];
        d.pready  = setup;
        d.pslverr = 1'b0;
        case (paddr)
            off_host_status, off_host_control, off_periph_prio, off_core_status,
            off_timer_csr, off_host_tx, off_host_rx, off_dma_select,
            off_irq_vector, off_io_window, off_dma_rights: known = 1'b1;
            default: known = 1'b0;
        endcase
        if (setup) begin
            d.prdata = 32'h0;
            case (paddr)
                off_host_status:  d.prdata = {29'h0, q.host_status};  // [R05]
                off_host_control: d.prdata = {30'h0, q.host_ctrl};
                off_periph_prio:  d.prdata = {31'h0, q.prio_level};
                off_core_status:  d.prdata = {31'h0, q.global_mask};
                off_timer_csr:    d.prdata = {29'h0, q.timer_csr};  // [R03]
                off_host_tx:      d.prdata = {8'h0, q.host_tx};
                off_host_rx:      d.prdata = {8'h0, q.host_rx};
                off_dma_select:   d.prdata = {27'h0, q.dma_sel};
                off_irq_vector:   d.prdata = {8'h0, q.irq_vec};
                off_io_window:    d.prdata = {8'h0, io_base_addr};
                off_dma_rights:   d.prdata = 32'h0000_0011;
                default:          d.prdata = 32'h0;  // [R19]
            endcase
            d.pslverr = !known;
        end
        // software writes; the host status word is read-only
        if (acc && pwrite) begin  // [R02]
            case (paddr)
                off_host_control: d.host_ctrl   = pwdata[1:0];
                off_periph_prio:  d.prio_level  = pwdata[periph_level_bit];
                off_core_status:  d.global_mask = pwdata[global_mask_bit];
                // only control bits of the timer are writable; flag clears by writing 1
                off_timer_csr: begin
                    d.timer_csr[timer_enable_bit] = pwdata[timer_enable_bit];
                    d.timer_csr[timer_ie_bit]     = pwdata[timer_ie_bit];
                    if (pwdata[timer_flag_bit]) begin
                        d.timer_csr[timer_flag_bit] = 1'b0;  // [R03]
                    end
                end
                off_host_tx: begin
                    d.host_tx = pwdata[23:0];
                    d.host_status[host_tx_empty_bit] = 1'b0;
                end
                off_dma_select:   d.dma_sel = pwdata[4:0];
                default: ;  // [R19]
            endcase
        end
        if (acc && !pwrite && paddr == off_host_rx) begin
            d.host_status[host_rx_full_bit] = 1'b0;
        end
        // dma on its own bus
        if (dma_wr_tx) begin  // [R13]
            d.host_tx = dma_in.wdata;
            d.host_status[host_tx_empty_bit] = 1'b0;
        end
        if (dma_rd_rx) begin
            d.host_status[host_rx_full_bit] = 1'b0;
        end
        // hardware sets win over clears
        if (host_tx_taken) begin
            d.host_status[host_tx_empty_bit] = 1'b1;
        end
        if (host_rx_load) begin
            d.host_rx = host_rx_data;
            d.host_status[host_rx_full_bit] = 1'b1;
        end
        if (timer_event && q.timer_csr[timer_enable_bit]) begin  // [R16]
            d.timer_csr[timer_flag_bit] = 1'b1;
        end
        // interrupt qualification
        irq_host_rx = host_rx_full && q.host_ctrl[host_rx_ie_bit];  // [R04]
        irq_host_tx = host_tx_empty && q.host_ctrl[host_tx_ie_bit];
        irq_timer   = timer_flag && q.timer_csr[timer_ie_bit];
        d.irq_req = (irq_host_rx || irq_host_tx || irq_timer)
                    && q.prio_level && q.global_mask;  // [R09] [R20]
        // vector is the entry point; short or long service and return stay with the core
        if (irq_host_rx) begin  // [R07] [R08]
            d.irq_vec = vec_host_rx_full;  // [R06]
        end else if (irq_host_tx) begin
            d.irq_vec = vec_host_tx_empty;
        end else if (irq_timer) begin
            d.irq_vec = vec_timer;
        end else begin
            d.irq_vec = 24'h0;
        end
        case (q.dma_sel)
            drs_host_tx_empty: sel_hit = host_tx_empty;  // [R18]
            drs_host_rx_full:  sel_hit = host_rx_full;
            drs_timer0:        sel_hit = timer_flag;
            default:           sel_hit = 1'b0;
        endcase
        d.dma_req = sel_hit;  // [R20]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q             <= '0;
            q.host_status <= host_status_rst;
            dma_ack_q     <= 1'b0;
            dma_rdata_q   <= 24'h0;
        end else if (clk_en) begin
            q           <= d;
            dma_ack_q   <= dma_in.valid;
            dma_rdata_q <= dma_rd_rx ? q.host_rx : 24'h0;  // [R12]
        end
    end

    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign irq_req   = q.irq_req;
    assign irq_vec   = q.irq_vec;
    assign dma_req   = q.dma_req;
    assign dma_ack   = dma_ack_q;
    assign dma_rdata = dma_rdata_q;

    // vector follows the qualified source one cycle later
    property p_vec;
        @(posedge pclk) disable iff (!presetn)
        clk_en && q.host_status[host_rx_full_bit] && q.host_ctrl[host_rx_ie_bit] && q.prio_level
        && q.global_mask |=> irq_req && irq_vec == 24'h000060;
    endproperty
    host_rx_vector_a: assert property (p_vec) else $error("host rx vector wrong");  // [R06]

    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(q.prio_level && q.global_mask) |=> !irq_req)
        else $error("irq passed a disabled gate");  // [R09]

    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(irq_req) |-> $past(q.host_status[0] && q.host_ctrl[0]) || $past(q.host_status[1] && q.host_ctrl[1])
        || $past(q.timer_csr[2] && q.timer_csr[1]))
        else $error("irq without enabled flag");  // [R04]

    tx_empty_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && setup && paddr == off_host_status |=> prdata[1] == $past(q.host_status[1]))
        else $error("tx empty not in bit 1");  // [R05]

    dma_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && q.dma_sel == 5'h14 |=> dma_req == $past(q.host_status[1]))
        else $error("dma select 10100 wrong");  // [R18]

    status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && acc && pwrite && paddr == off_host_status && !host_tx_taken && !host_rx_load
        && !dma_in.valid |=> q.host_status == $past(q.host_status))
        else $error("status changed by write");  // [R02]

    unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && setup && !known |=> prdata == 32'h0 && pslverr)
        else $error("unmapped read not zero");  // [R19]

    dma_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && dma_in.valid && dma_in.write && dma_in.addr == 24'hffffd6 |=> q.host_rx == $past(q.host_rx)
        || $past(host_rx_load))
        else $error("dma wrote receive register");  // [R12]

    window_a: assert property (@(posedge pclk) disable iff (!presetn)
        dma_in_win |-> dma_in.addr >= 24'hffff80)
        else $error("window decode wrong");  // [R01]
endmodule
`default_nettype wire

// ==== hdl/periph_io_pkg.sv ====
package periph_io_pkg;

    // internal i/o window at the top of x data memory
    localparam logic [23:0] io_base_addr      = 24'hffff80;
    localparam int          io_window_words   = 128;
    // apb byte offsets of the register words
    localparam logic [11:0] off_host_status   = 12'h000;
    localparam logic [11:0] off_host_control  = 12'h004;
    localparam logic [11:0] off_periph_prio   = 12'h008;
    localparam logic [11:0] off_core_status   = 12'h00c;
    localparam logic [11:0] off_timer_csr     = 12'h010;
    localparam logic [11:0] off_host_tx       = 12'h014;
    localparam logic [11:0] off_host_rx       = 12'h018;
    localparam logic [11:0] off_dma_select    = 12'h01c;
    localparam logic [11:0] off_irq_vector    = 12'h020;
    localparam logic [11:0] off_io_window     = 12'h024;
    localparam logic [11:0] off_dma_rights    = 12'h028;
    // field positions
    localparam int          host_tx_empty_bit = 1;
    localparam int          host_rx_full_bit  = 0;
    localparam int          host_rx_ie_bit    = 0;
    localparam int          host_tx_ie_bit    = 1;
    localparam int          timer_enable_bit  = 0;
    localparam int          timer_ie_bit      = 1;
    localparam int          timer_flag_bit    = 2;
    localparam int          periph_level_bit  = 0;
    localparam int          global_mask_bit   = 0;
    // vector of the host receive-full source, and of others
    localparam logic [23:0] vec_host_rx_full  = 24'h000060;
    localparam logic [23:0] vec_host_tx_empty = 24'h000062;
    localparam logic [23:0] vec_timer         = 24'h000024;
    // dma request selector code for host transmit empty
    localparam logic [4:0]  drs_host_tx_empty = 5'h14;
    localparam logic [4:0]  drs_host_rx_full  = 5'h13;
    localparam logic [4:0]  drs_timer0        = 5'h10;
    // reset value of host status, and opcode count of short service code
    localparam logic [2:0]  host_status_rst   = 3'h2;
    localparam int          short_isr_ops     = 2;

    typedef struct packed {
        logic [2:0]  host_status;
        logic [1:0]  host_ctrl;
        logic        prio_level;
        logic        global_mask;
        logic [2:0]  timer_csr;
        logic [4:0]  dma_sel;
        logic [23:0] host_tx;
        logic [23:0] host_rx;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq_req;
        logic [23:0] irq_vec;
        logic        dma_req;
    } regs_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [23:0] addr;
        logic [23:0] wdata;
    } dma_req_type;

endpackage

// ==== hdl/io_window_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module io_window_decode
    import periph_io_pkg::*;
(
    // dma access
    input  wire logic        dma_valid,
    input  wire logic        dma_write,
    input  wire logic [23:0] dma_addr,
    // decode
    output logic             in_window,
    output logic [6:0]       word_idx,
    output logic             dma_ok
);
    localparam logic [6:0] idx_host_tx = 7'h55;
    localparam logic [6:0] idx_host_rx = 7'h56;

    always_comb begin
        in_window = dma_addr[23:7] == io_base_addr[23:7];  // [R01]
        word_idx  = dma_addr[6:0];
        dma_ok    = 1'b0;
        if (dma_valid && in_window) begin
            // transmit side writable only, receive side readable only
            if (word_idx == idx_host_tx) begin
                dma_ok = dma_write;  // [R12]
            end else if (word_idx == idx_host_rx) begin
                dma_ok = !dma_write;  // [R12]
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/core_dma_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module core_dma_model
    import periph_io_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // private dma bus toward the block
    output var  dma_req_type dma_in,
    input  wire logic [23:0] dma_rdata,
    input  wire logic        dma_ack
);
    initial begin
        dma_in = '0;
    end

    // request held on the own dma bus until acknowledged or 20 cycles pass, core untouched
    task automatic xfer(input logic wr, input logic [23:0] a, input logic [23:0] wd, input int gap,
                        output logic [23:0] rd, output logic ok);
        int n;
        wait (presetn === 1'b1);
        repeat (gap) @(posedge pclk);
        dma_in <= '{valid: 1'b1, write: wr, addr: a, wdata: wd};
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (dma_ack !== 1'b1 && n < 20);
        rd = dma_rdata;
        ok = dma_ack;
        // released lines show the inverse, never the stale value
        dma_in <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/test_peripheral_io_space_service.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_io_space_service
    import periph_io_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, host_rx_load, host_tx_taken, timer_event;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, d, d2;
    logic        pready, pslverr, er, irq_req, dma_req, ok;
    logic [23:0] host_rx_data, irq_vec, dma_rdata, dr;
    logic        dma_ack;
    dma_req_type dma_in;
    int          err_total, total_checks, s;

    periph_io_space #(.host_irq_sources(2), .host_dma_sources(2)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_rx_load(host_rx_load), .host_rx_data(host_rx_data),
        .host_tx_taken(host_tx_taken), .timer_event(timer_event), .dma_in(dma_in),
        .dma_rdata(dma_rdata), .dma_ack(dma_ack), .irq_req(irq_req), .irq_vec(irq_vec),
        .dma_req(dma_req));

    core_dma_model dm (.pclk(pclk), .presetn(presetn), .dma_in(dma_in), .dma_rdata(dma_rdata),
                       .dma_ack(dma_ack));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic exp_irq(input logic ie, input logic lvl, input logic msk);
        return ie & lvl & msk;
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        er = pslverr;
        if (n >= 50) chk("apb answer", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, r);
    endtask

    // one-cycle event strobe: 0 timer event, 1 host receive load, else host transmit taken
    task automatic pulse(input int k);
        case (k)
            0:       timer_event <= 1'b1;
            1:       host_rx_load <= 1'b1;
            default: host_tx_taken <= 1'b1;
        endcase
        @(posedge pclk);
        {timer_event, host_rx_load, host_tx_taken} <= 3'b0;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        #(50 * 6000);
        err_total++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, host_rx_load, host_tx_taken, timer_event} = '0;
        {paddr, pwdata, host_rx_data} = '0;
        err_total = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s = $urandom(32'h620d);
        rd(off_host_status, 32'(host_status_rst), "host status reset");
        rd(off_io_window, 32'(io_base_addr), "window base");
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            apb(1'b1, off_host_status, d);
            rd(off_host_status, 32'(host_status_rst), "status after write");
            paddr <= 12'h02c + 12'(($urandom % 990) * 4);
            @(posedge pclk);
            apb(1'b1, paddr, d);
            rd(paddr, 32'h0, "unmapped data");
            chk("unmapped error", 32'h1, 32'(er));
        end
        // timer: configure while disabled, then enable
        apb(1'b1, off_timer_csr, 32'h2);
        apb(1'b1, off_timer_csr, 32'h3);
        pulse(0);
        rd(off_timer_csr, 32'h7, "timer csr flag");
        apb(1'b1, off_periph_prio, 32'h1);
        apb(1'b1, off_core_status, 32'h1);
        repeat (2) @(posedge pclk);
        chk("timer irq", 32'h1, 32'(irq_req));
        chk("timer vector", 32'(vec_timer), 32'(irq_vec));
        apb(1'b1, off_timer_csr, 32'h7);
        rd(off_timer_csr, 32'h3, "timer flag cleared");
        chk("irq after clear", 32'h0, 32'(irq_req));
        // host receive: three enables in every combination
        d = 32'($urandom % 32'h1000000);
        host_rx_data <= d[23:0];
        pulse(1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, off_host_control, {31'h0, i[0]});
            apb(1'b1, off_periph_prio, {31'h0, i[1]});
            apb(1'b1, off_core_status, {31'h0, i[2]});
            repeat (2) @(posedge pclk);
            chk("irq gate", 32'(exp_irq(i[0], i[1], i[2])), 32'(irq_req));
        end
        chk("rx vector", 32'(vec_host_rx_full), 32'(irq_vec));
        rd(off_host_rx, d, "host rx data");
        repeat (2) @(posedge pclk);
        chk("irq after rx read", 32'h0, 32'(irq_req));
        // dma on transmit empty, interrupt of that event kept off
        apb(1'b1, off_host_control, 32'h0);
        apb(1'b1, off_dma_select, 32'(drs_host_tx_empty));
        repeat (2) @(posedge pclk);
        chk("dma req tx empty", 32'h1, 32'(dma_req));
        d2 = 32'($urandom % 32'h1000000);
        dm.xfer(1'b1, 24'hffffd5, d2[23:0], int'($urandom % 4), dr, ok);
        chk("dma write ack", 32'h1, 32'(ok));
        repeat (2) @(posedge pclk);
        chk("dma req after write", 32'h0, 32'(dma_req));
        rd(off_host_status, 32'h0, "tx empty cleared");
        pulse(2);
        chk("dma req again", 32'h1, 32'(dma_req));
        dm.xfer(1'b0, 24'hffffd5, 24'h0, 1, dr, ok);
        chk("dma read of tx", 32'h0, 32'(dr));
        host_rx_data <= d2[23:0];
        pulse(1);
        dm.xfer(1'b0, 24'hffffd6, 24'h0, 0, dr, ok);
        chk("dma read of rx", d2, 32'(dr));
        dm.xfer(1'b1, 24'hffffd6, ~d2[23:0], 2, dr, ok);
        rd(off_host_rx, d2, "rx kept");
        dm.xfer(1'b0, 24'h001000, 24'h0, 0, dr, ok);
        chk("outside window", 32'h0, 32'(dr));
        close_out();
    end
endmodule
`default_nettype wire
